/* File: verilog/fwsc_ctrl.sv */
`timescale 1ns/1ps
module fwsc_ctrl import fwsc_pkg::*; #(
  parameter int KEY_W = FWSC_KEY_W
) (
  input wire logic mclk, // System clock, 20 MHz
  input wire logic rstn, // Async reset, active low
  input wire logic [1:0] boot_mode_pin, // Boot mode straps from pins
  input wire logic [3:0] pwr_mode, // Current operating mode
  input wire logic key_wr, // Write strobe to key field
  input wire logic [KEY_W-1:0] key_wdata, // Key write data
  input wire logic stb_wr, // Write strobe to standby bit
  input wire logic stb_wdata, // Standby write data
  input wire logic fetch_in_ram, // Current instruction came from RAM
  input wire logic irq_req, // Interrupt accepted this cycle
  input wire logic acc_valid, // CPU memory access
  input wire logic acc_we, // Access is a write
  input wire logic [15:0] acc_addr, // Access address
  input wire logic [7:0] acc_wdata, // Access write data
  output logic [KEY_W-1:0] command_enable_key, // Key readback
  output logic flash_standby_bit, // Standby bit readback
  output logic flash_pwr_cut, // Cut flash steady-state current
  output logic vector_fetch_ok, // Flash awake for vector fetch
  output logic flash_sel, // Registered flash select pulse
  output logic flash_we, // Registered write qualifier
  output logic [13:0] flash_addr, // Registered flash byte offset
  output logic cmd_valid, // Command accepted pulse
  output fwsc_cmd_t cmd_code, // Accepted command
  output logic [15:0] cmd_addr, // Command target address
  output logic [7:0] cmd_data // Command data
);

  if (KEY_W != FWSC_KEY_W) begin : g_bad_key_w
    $error("fwsc_ctrl: key field must be 4 bits");
  end

  // ****************************************
  // Decoding helpers
  // ****************************************
  function automatic logic in_flash(input logic [15:0] a);
    in_flash = (a >= FWSC_FLASH_BASE) && (a <= FWSC_FLASH_LAST);
  endfunction

  function automatic logic is_low_power(input logic [3:0] m);
    is_low_power = (m >= FWSC_PM_IDLE0) && (m <= FWSC_PM_STOP);
  endfunction

  // ****************************************
  // Boot mode straps
  // ****************************************
  logic [1:0] boot_mode;
  logic reg_active;

  fwsc_sync #(
    .W(2)
  ) u_boot_sync (
    .mclk(mclk),
    .rstn(rstn),
    .din(boot_mode_pin),
    .dout(boot_mode)
  );

  // Parallel PROM programming bypasses the key register and command sequencer; standby and flash select keep running
  assign reg_active = (boot_mode == FWSC_BOOT_MCU) || (boot_mode == FWSC_BOOT_SERIAL);

  // ****************************************
  // Command enable key
  // ****************************************
  logic [KEY_W-1:0] key_reg;
  logic cmd_en;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      key_reg <= FWSC_KEY_RESET;
    end else if (key_wr && reg_active) begin
      key_reg <= key_wdata;
    end
  end

  // Only the exact pattern unlocks; a corrupted write stays safe
  assign cmd_en = reg_active && (key_reg == FWSC_KEY_UNLOCK);
  assign command_enable_key = key_reg;

  // ****************************************
  // Flash access path
  // ****************************************
  logic flash_hit;

  assign flash_hit = acc_valid && in_flash(acc_addr);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flash_sel <= 1'b0;
      flash_we <= 1'b0;
      flash_addr <= 14'h0000;
    end else begin
      flash_sel <= flash_hit;
      flash_we <= flash_hit && acc_we;
      if (flash_hit) flash_addr <= acc_addr[FWSC_FLASH_AW-1:0];
    end
  end

  fwsc_cmd_seq u_cmd_seq (
    .mclk(mclk),
    .rstn(rstn),
    .enable(cmd_en),
    .wr_valid(flash_hit && acc_we),
    .wr_addr(acc_addr),
    .wr_data(acc_wdata),
    .cmd_valid(cmd_valid),
    .cmd_code(cmd_code),
    .cmd_addr(cmd_addr),
    .cmd_data(cmd_data)
  );

  // ****************************************
  // Flash standby
  // ****************************************
  logic stb_reg;
  logic lp_reg;
  logic lp_enter;
  logic run_mode;
  logic stb_clear;
  logic stb_set;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) lp_reg <= 1'b0;
    else lp_reg <= is_low_power(pwr_mode);
  end

  assign lp_enter = is_low_power(pwr_mode) && !lp_reg;
  assign run_mode = !is_low_power(pwr_mode);

  // A set made by code fetched from flash is dropped
  assign stb_set = stb_wr && stb_wdata && fetch_in_ram && run_mode;
  // Clear beats set: the flash must be awake whenever it is touched
  assign stb_clear = (stb_wr && !stb_wdata) || flash_hit
    || irq_req
    || lp_enter;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stb_reg <= 1'b0;
    end else if (stb_clear) begin
      stb_reg <= 1'b0;
    end else if (stb_set) begin
      stb_reg <= 1'b1;
    end
  end

  assign flash_standby_bit = stb_reg;
  // Vector fetch waits one cycle for the wake-up to land
  assign vector_fetch_ok = !stb_reg;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) flash_pwr_cut <= 1'b0;
    else flash_pwr_cut <= is_low_power(pwr_mode)
      || (stb_reg && run_mode && !stb_clear);
  end

endmodule // fwsc_ctrl

/* File: verilog/fwsc_pkg.sv */
package fwsc_pkg;

  // ****************************************
  // Address map
  // ****************************************
  localparam logic [15:0] FWSC_FLASH_BASE = 16'hc000;
  localparam logic [15:0] FWSC_FLASH_LAST = 16'hffff;
  localparam int FWSC_FLASH_BYTES = 16384;
  localparam int FWSC_FLASH_AW = 14;
  localparam int FWSC_CMD_AW = 12;
  localparam logic [15:0] FWSC_SEC_ADDR = 16'hff7f;

  // ****************************************
  // Key field
  // ****************************************
  localparam int FWSC_KEY_W = 4;
  localparam logic [3:0] FWSC_KEY_UNLOCK = 4'h3;
  localparam logic [3:0] FWSC_KEY_LOCK = 4'hc;
  localparam logic [3:0] FWSC_KEY_RESET = FWSC_KEY_LOCK;

  // ****************************************
  // Command sequence codes
  // ****************************************
  localparam logic [11:0] FWSC_A_555 = 12'h555;
  localparam logic [11:0] FWSC_A_AAA = 12'haaa;
  localparam logic [7:0] FWSC_D_AA = 8'haa;
  localparam logic [7:0] FWSC_D_55 = 8'h55;
  localparam logic [7:0] FWSC_D_PROG = 8'ha0;
  localparam logic [7:0] FWSC_D_ERASE = 8'h80;
  localparam logic [7:0] FWSC_D_ID = 8'h90;
  localparam logic [7:0] FWSC_D_EXIT = 8'hf0;
  localparam logic [7:0] FWSC_D_SEC = 8'ha5;
  localparam logic [7:0] FWSC_D_SECT = 8'h30;
  localparam logic [7:0] FWSC_D_CHIP = 8'h10;
  localparam logic [7:0] FWSC_D_SECDAT = 8'h00;

  typedef enum logic [2:0] {
    FWSC_CMD_PROG = 3'h1,
    FWSC_CMD_SECT = 3'h2,
    FWSC_CMD_CHIP = 3'h3,
    FWSC_CMD_ID_IN = 3'h4,
    FWSC_CMD_ID_OUT = 3'h5,
    FWSC_CMD_SEC = 3'h6
  } fwsc_cmd_t;

  // ****************************************
  // Operating and boot modes
  // ****************************************
  typedef enum logic [3:0] {
    FWSC_PM_NORMAL1 = 4'h0,
    FWSC_PM_NORMAL2 = 4'h1,
    FWSC_PM_SLOW1 = 4'h2,
    FWSC_PM_SLOW2 = 4'h3,
    FWSC_PM_IDLE0 = 4'h4,
    FWSC_PM_IDLE1 = 4'h5,
    FWSC_PM_IDLE2 = 4'h6,
    FWSC_PM_SLEEP0 = 4'h7,
    FWSC_PM_SLEEP1 = 4'h8,
    FWSC_PM_SLEEP2 = 4'h9,
    FWSC_PM_STOP = 4'ha
  } fwsc_pm_t;

  localparam logic [1:0] FWSC_BOOT_MCU = 2'h0;
  localparam logic [1:0] FWSC_BOOT_SERIAL = 2'h1;
  localparam logic [1:0] FWSC_BOOT_PARALLEL = 2'h2;

endpackage

/* File: verilog/fwsc_sync.sv */
`timescale 1ns/1ps
module fwsc_sync import fwsc_pkg::*; #(
  parameter int W = 2
) (
  input wire logic mclk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic [W-1:0] din, // Asynchronous level
  output logic [W-1:0] dout // Filtered level
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  if (W < 1) begin : g_bad_width
    $error("fwsc_sync: W must be at least 1");
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A bit moves only once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          dout[i] <= 1'b0;
        end else if (s2_reg[i] == s3_reg[i]) begin
          dout[i] <= s3_reg[i];
        end
      end
    end
  endgenerate
endmodule // fwsc_sync

/* File: verilog/fwsc_cmd_seq.sv */
`timescale 1ns/1ps
module fwsc_cmd_seq import fwsc_pkg::*; (
  input wire logic mclk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic enable, // Command execution allowed
  input wire logic wr_valid, // Write cycle into flash space
  input wire logic [15:0] wr_addr, // Write address
  input wire logic [7:0] wr_data, // Write data
  output logic cmd_valid, // One-cycle command pulse
  output fwsc_cmd_t cmd_code, // Recognised command
  output logic [15:0] cmd_addr, // Target address of command
  output logic [7:0] cmd_data // Data of command
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_UL1 = 4'b0001,
    S_UL2 = 4'b0011,
    S_PROG = 4'b0010,
    S_ER3 = 4'b0110,
    S_ER4 = 4'b0111,
    S_ER5 = 4'b0101,
    S_SEC = 4'b0100
  } fwsc_seq_t;

  fwsc_seq_t state_reg;
  fwsc_seq_t state_next;
  logic hit_next;
  fwsc_cmd_t code_next;
  logic [11:0] a12;

  assign a12 = wr_addr[FWSC_CMD_AW-1:0];

  always_comb begin
    state_next = state_reg;
    hit_next = 1'b0;
    code_next = FWSC_CMD_PROG;
    if (wr_valid) begin
      state_next = S_IDLE;
      unique case (state_reg)
        S_IDLE: begin
          if (a12 == FWSC_A_555 && wr_data == FWSC_D_AA) state_next = S_UL1;
          else if (wr_data == FWSC_D_EXIT) begin
            hit_next = 1'b1;
            code_next = FWSC_CMD_ID_OUT;
          end
        end
        S_UL1: begin
          if (a12 == FWSC_A_AAA && wr_data == FWSC_D_55) state_next = S_UL2;
        end
        S_UL2: begin
          if (a12 == FWSC_A_555) begin
            unique case (wr_data)
              FWSC_D_PROG: state_next = S_PROG;
              FWSC_D_ERASE: state_next = S_ER3;
              FWSC_D_SEC: state_next = S_SEC;
              FWSC_D_ID: begin
                hit_next = 1'b1;
                code_next = FWSC_CMD_ID_IN;
              end
              FWSC_D_EXIT: begin
                hit_next = 1'b1;
                code_next = FWSC_CMD_ID_OUT;
              end
              default: state_next = S_IDLE;
            endcase
          end
        end
        S_PROG: begin
          hit_next = 1'b1;
          code_next = FWSC_CMD_PROG;
        end
        S_ER3: begin
          if (a12 == FWSC_A_555 && wr_data == FWSC_D_AA) state_next = S_ER4;
        end
        S_ER4: begin
          if (a12 == FWSC_A_AAA && wr_data == FWSC_D_55) state_next = S_ER5;
        end
        S_ER5: begin
          if (wr_data == FWSC_D_SECT) begin
            hit_next = 1'b1;
            code_next = FWSC_CMD_SECT;
          end else if (a12 == FWSC_A_555 && wr_data == FWSC_D_CHIP) begin
            hit_next = 1'b1;
            code_next = FWSC_CMD_CHIP;
          end
        end
        S_SEC: begin
          if (wr_addr == FWSC_SEC_ADDR && wr_data == FWSC_D_SECDAT) begin
            hit_next = 1'b1;
            code_next = FWSC_CMD_SEC;
          end
        end
        default: state_next = S_IDLE;
      endcase
    end
    // Locked key aborts any partial sequence
    if (!enable) begin
      state_next = S_IDLE;
      hit_next = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) state_reg <= S_IDLE;
    else state_reg <= state_next;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmd_valid <= 1'b0;
      cmd_code <= FWSC_CMD_PROG;
      cmd_addr <= 16'h0000;
      cmd_data <= 8'h00;
    end else begin
      cmd_valid <= hit_next;
      if (hit_next) begin
        cmd_code <= code_next;
        cmd_addr <= wr_addr;
        cmd_data <= wr_data;
      end
    end
  end
endmodule // fwsc_cmd_seq

/* File: bench/fwsc_ctrl_chk.sv */
`timescale 1ns/1ps
module fwsc_ctrl_chk import fwsc_pkg::*; #(
  parameter int KEY_W = FWSC_KEY_W
) (
  input wire logic mclk, // Clock
  input wire logic rstn, // Reset
  input wire logic [1:0] boot_mode_pin, // Straps
  input wire logic [3:0] pwr_mode, // Mode
  input wire logic key_wr, // Key strobe
  input wire logic [KEY_W-1:0] key_wdata, // Key data
  input wire logic stb_wr, // Standby strobe
  input wire logic fetch_in_ram, // From RAM
  input wire logic irq_req, // Interrupt
  input wire logic acc_valid, // Access
  input wire logic [15:0] acc_addr, // Address
  input wire logic [KEY_W-1:0] command_enable_key, // Key
  input wire logic flash_standby_bit, // Standby
  input wire logic flash_pwr_cut, // Current cut
  input wire logic cmd_valid // Command
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  logic hit;
  logic lp;
  assign hit = acc_valid && acc_addr >= FWSC_FLASH_BASE;
  // Codes above the last low-power mode run like the normal modes
  assign lp = (pwr_mode >= FWSC_PM_IDLE0) && (pwr_mode <= FWSC_PM_STOP);
  // Straps pass a filter, so only a long-settled MCU or serial strap guarantees the write lands
  a_key_write_take: assert property (
    (boot_mode_pin == FWSC_BOOT_MCU)[*8] ##0 key_wr |=> command_enable_key == $past(key_wdata))
    else $error("key write not taken");
  a_lock_blocks: assert property (
    acc_valid && command_enable_key != FWSC_KEY_UNLOCK |=> !cmd_valid)
    else $error("command while locked");
  a_access_clr: assert property (hit |=> !flash_standby_bit)
    else $error("standby kept over flash access");
  a_irq_clr: assert property (irq_req |=> !flash_standby_bit)
    else $error("standby kept over interrupt");
  a_lowpwr_clr: assert property (lp |=> !flash_standby_bit)
    else $error("standby kept in low power");
  a_lowpwr_cut: assert property (lp |=> flash_pwr_cut)
    else $error("current not cut in low power");
  a_flash_set_void: assert property (
    stb_wr && !fetch_in_ram && !flash_standby_bit |=> !flash_standby_bit)
    else $error("standby set from flash");
  a_ram_stb_cut: assert property (
    pwr_mode < 4'h4 && !irq_req && !hit && !stb_wr |=> flash_pwr_cut == $past(flash_standby_bit))
    else $error("run-mode cut wrong");
  c_cmd: cover property (cmd_valid);
  c_stb_set: cover property ($rose(flash_standby_bit));
  c_run_cut: cover property (flash_pwr_cut && pwr_mode < 4'h4);
endmodule // fwsc_ctrl_chk

/* File: bench/fwsc_cpu_model.sv */
`timescale 1ns/1ps
module fwsc_cpu_model (
  input wire logic mclk, // Clock
  input wire logic flash_standby_bit, // Standby readback
  output logic key_wr, // Key strobe
  output logic [3:0] key_wdata, // Key data
  output logic stb_wr, // Standby strobe
  output logic stb_wdata, // Standby data
  output logic fetch_in_ram, // Running from RAM
  output logic irq_req, // Interrupt taken
  output logic acc_valid, // Access
  output logic acc_we, // Write access
  output logic [15:0] acc_addr, // Address
  output logic [7:0] acc_wdata // Write data
);
  // ****************************************
  // Core behaviour
  // ****************************************
  logic interrupt_master_enable;
  initial begin
    {key_wr, key_wdata, stb_wr, stb_wdata, fetch_in_ram, irq_req} = 9'h0c0;
    {acc_valid, acc_we, acc_addr, acc_wdata} = '0;
    interrupt_master_enable = 1'b1;
  end
  task automatic wr_key(input logic [3:0] k);
    @(negedge mclk);
    {key_wr, key_wdata} = {1'b1, k};
    @(negedge mclk);
    {key_wr, key_wdata} = {1'b0, ~k};
  endtask
  // Interrupts go off before the bit is touched
  task automatic stb_set(input logic v, input logic ram);
    @(negedge mclk);
    interrupt_master_enable = 1'b0;
    {fetch_in_ram, stb_wr, stb_wdata} = {ram, 1'b1, v};
    @(negedge mclk);
    {stb_wr, stb_wdata} = {1'b0, ~v};
  endtask
  task automatic back_to_flash();
    if (flash_standby_bit) begin
      stb_set(1'b0, 1'b1);
    end
    @(negedge mclk);
    fetch_in_ram = 1'b0;
    interrupt_master_enable = 1'b1;
  endtask
  // Released lines flip so a stale value is never mistaken for a live one
  task automatic access(input logic we, input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    {acc_valid, acc_we, acc_addr, acc_wdata} = {1'b1, we, a, d};
    @(negedge mclk);
    {acc_valid, acc_we, acc_addr, acc_wdata} = {1'b0, ~we, ~a, ~d};
  endtask
  // Non-maskable source, so it may arrive while standby is set
  task automatic irq();
    @(negedge mclk);
    irq_req = 1'b1;
    @(negedge mclk);
    irq_req = 1'b0;
  endtask
endmodule // fwsc_cpu_model

/* File: bench/fwsc_ctrl_test.sv */
`timescale 1ns/1ps
`define chk(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module fwsc_ctrl_test import fwsc_pkg::*; ();
  logic mclk, rstn, key_wr, stb_wr, stb_wdata, fetch_in_ram, irq_req, acc_valid, acc_we;
  logic flash_standby_bit, flash_pwr_cut, vector_fetch_ok, flash_sel, flash_we, cmd_valid;
  logic [1:0] boot_mode_pin;
  logic [3:0] pwr_mode, key_wdata, command_enable_key;
  logic [15:0] acc_addr, cmd_addr;
  logic [7:0] acc_wdata, cmd_data;
  logic [13:0] flash_addr;
  fwsc_cmd_t cmd_code;
  int compares = 0;
  int miscompares = 0;
  logic [27:0] rows [27];
  fwsc_ctrl uut (.mclk, .rstn, .boot_mode_pin, .pwr_mode, .key_wr, .key_wdata, .stb_wr,
    .stb_wdata, .fetch_in_ram, .irq_req, .acc_valid, .acc_we, .acc_addr, .acc_wdata,
    .command_enable_key, .flash_standby_bit, .flash_pwr_cut, .vector_fetch_ok, .flash_sel,
    .flash_we, .flash_addr, .cmd_valid, .cmd_code, .cmd_addr, .cmd_data);
  fwsc_cpu_model cpu (.mclk, .flash_standby_bit, .key_wr, .key_wdata, .stb_wr, .stb_wdata,
    .fetch_in_ram, .irq_req, .acc_valid, .acc_we, .acc_addr, .acc_wdata);
  // ****************************************
  // Tasks
  // ****************************************
  task automatic results();
    if (miscompares == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic reset_chk();
    rstn = 1'b0;
    repeat (20) @(negedge mclk);
    `chk("key rst", FWSC_KEY_RESET, command_enable_key)
    `chk("stb rst", 1'b0, flash_standby_bit)
    rstn = 1'b1;
    repeat (5) @(negedge mclk);
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    #(3000 * 50);
    miscompares++;
    results();
  end
  initial begin
    // Address, data, then 8 plus command code when a command is due
    rows = '{28'hc555aa0, 28'hdaaa550, 28'hc555a00, 28'hc1235a9, 28'hc555aa0, 28'hcaaa550,
      28'he555800, 28'hc555aa0, 28'hfaaa550, 28'he23430a, 28'hc555aa0, 28'hcaaa550,
      28'hc555800, 28'hc555aa0, 28'hcaaa550, 28'hd55510b, 28'hc555aa0, 28'hcaaa550,
      28'hc55590c, 28'hd000f0d, 28'hc555aa0, 28'hcaaa550, 28'hc555f0d, 28'hc555aa0,
      28'hcaaa550, 28'hc555a50, 28'hff7f00e};
    boot_mode_pin = FWSC_BOOT_MCU;
    pwr_mode = FWSC_PM_NORMAL1;
    reset_chk();
    cpu.wr_key(FWSC_KEY_UNLOCK);
    for (int i = 0; i < 27; i++) begin
      cpu.access(1'b1, rows[i][27:12], rows[i][11:4]);
      `chk("cmd_valid", rows[i][3], cmd_valid)
      `chk("flash_we", 1'b1, flash_we)
      `chk("flash_addr", rows[i][25:12], flash_addr)
      if (rows[i][3]) begin
        `chk("cmd_code", rows[i][2:0], cmd_code)
        `chk("cmd_data", rows[i][11:4], cmd_data)
        `chk("cmd_addr", rows[i][27:12], cmd_addr)
      end
    end
    for (int k = 0; k < 2; k++) begin
      cpu.wr_key(k ? 4'h5 : FWSC_KEY_LOCK);
      for (int i = 0; i < 4; i++) begin
        cpu.access(1'b1, rows[i][27:12], rows[i][11:4]);
        `chk("locked cmd", 1'b0, cmd_valid)
      end
    end
    cpu.wr_key(FWSC_KEY_LOCK);
    boot_mode_pin = FWSC_BOOT_PARALLEL;
    repeat (8) @(negedge mclk);
    cpu.wr_key(FWSC_KEY_UNLOCK);
    `chk("key par", FWSC_KEY_LOCK, command_enable_key)
    boot_mode_pin = FWSC_BOOT_SERIAL;
    repeat (8) @(negedge mclk);
    cpu.wr_key(FWSC_KEY_UNLOCK);
    `chk("key ser", FWSC_KEY_UNLOCK, command_enable_key)
    cpu.access(1'b1, 16'hc555, 8'hf0);
    `chk("cmd ser", 1'b1, cmd_valid)
    cpu.wr_key(FWSC_KEY_LOCK);
    boot_mode_pin = FWSC_BOOT_MCU;
    repeat (8) @(negedge mclk);
    cpu.stb_set(1'b1, 1'b1);
    `chk("stb ram", 1'b1, flash_standby_bit)
    `chk("vec busy", 1'b0, vector_fetch_ok)
    @(negedge mclk);
    `chk("cut ram", 1'b1, flash_pwr_cut)
    cpu.irq();
    `chk("stb irq", 1'b0, flash_standby_bit)
    `chk("vec ok", 1'b1, vector_fetch_ok)
    cpu.stb_set(1'b1, 1'b1);
    cpu.access(1'b0, 16'hbfff, 8'h00);
    `chk("stb bfff", 1'b1, flash_standby_bit)
    `chk("sel bfff", 1'b0, flash_sel)
    cpu.access(1'b0, FWSC_FLASH_BASE, 8'h00);
    `chk("stb c000", 1'b0, flash_standby_bit)
    `chk("sel c000", 1'b1, flash_sel)
    `chk("we c000", 1'b0, flash_we)
    for (int m = 4; m <= 10; m++) begin
      cpu.stb_set(1'b1, 1'b1);
      pwr_mode = 4'(m);
      @(negedge mclk);
      `chk("stb lp", 1'b0, flash_standby_bit)
      `chk("cut lp", 1'b1, flash_pwr_cut)
      pwr_mode = FWSC_PM_NORMAL1;
    end
    cpu.stb_set(1'b1, 1'b1);
    cpu.back_to_flash();
    `chk("stb back", 1'b0, flash_standby_bit)
    cpu.stb_set(1'b1, 1'b0);
    @(negedge mclk);
    `chk("stb flash", 1'b0, flash_standby_bit)
    `chk("cut flash", 1'b0, flash_pwr_cut)
    cpu.wr_key(FWSC_KEY_UNLOCK);
    reset_chk();
    results();
  end
endmodule // fwsc_ctrl_test
bind fwsc_ctrl fwsc_ctrl_chk #(.KEY_W(KEY_W)) u_chk (.mclk, .rstn, .boot_mode_pin, .pwr_mode,
  .key_wr, .key_wdata, .stb_wr, .fetch_in_ram, .irq_req, .acc_valid, .acc_addr,
  .command_enable_key, .flash_standby_bit, .flash_pwr_cut, .cmd_valid);
